// [hdl/hsc_consts.vh]
// Constants of the harvester state and event control block
`ifndef HSC_CONSTS_VH
`define HSC_CONSTS_VH
`define HSC_CLK_KHZ         10000
`define HSC_THERM_PERIOD_MS 8000
`define HSC_CFG_PERIOD_MS   2000
`define HSC_DIS_PERIOD_MS   1000
`define HSC_SLEEP_MAX_SRC   7'h0C
`define HSC_IRQ_BIT_READY   0
`define HSC_IRQ_BIT_MON     1
`define HSC_IRQ_EN_RESET    2'h1
`define HSC_APM_MODE_PULSE  1'h0
`define HSC_APM_MODE_METER  1'h1
`endif

// [hdl/hsc_pin_sync.v]
// Three-stage synchroniser whose output follows once stages two and three agree
`timescale 1ns/1ns
module hsc_pin_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] pinIn,
  output reg  [W-1:0] level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // Stage one feeds stage two only; a change counts when two and three agree
  always @(posedge clk) begin
    if (!nrst) begin
      s1_q  <= {W{1'b0}};
      s2_q  <= {W{1'b0}};
      s3_q  <= {W{1'b0}};
      level <= {W{1'b0}};
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level);
    end
  end
endmodule // hsc_pin_sync

// [hdl/hsc_power_monitor.v]
// Two-phase average power monitor: measure for a window, then wait as long
`timescale 1ns/1ns
`include "hsc_consts.vh"
module hsc_power_monitor (
  input  wire        clk,
  input  wire        nrst,
  input  wire        enable,
  input  wire        mode,
  input  wire [23:0] windowCycles,
  input  wire        boostPulse,
  input  wire [7:0]  energyQuanta,
  output reg         monDone,
  output reg  [31:0] monData
);
  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_MEAS = 2'h1;
  localparam [1:0] PH_WAIT = 2'h2;

  reg [1:0]  phase_q;
  reg [23:0] tick_q;
  reg [31:0] acc_q;
  wire       winEnd = (tick_q >= windowCycles - 24'h000001);

  // Window timer, accumulator and result strobe
  always @(posedge clk) begin
    if (!nrst) begin
      phase_q <= PH_IDLE;
      tick_q  <= 24'h000000;
      acc_q   <= 32'h00000000;
      monDone <= 1'b0;
      monData <= 32'h00000000;
    end else begin
      monDone <= 1'b0;
      if (!enable) begin
        phase_q <= PH_IDLE;
        tick_q  <= 24'h000000;
        acc_q   <= 32'h00000000;
      end else begin
        case (phase_q)
          PH_IDLE: begin
            phase_q <= PH_MEAS;
            tick_q  <= 24'h000000;
            acc_q   <= 32'h00000000;
          end
          PH_MEAS: begin
            // Pulse mode counts boost pulses, meter mode sums energy quanta
            if (mode == `HSC_APM_MODE_PULSE)
              acc_q <= acc_q + {31'h00000000, boostPulse};
            else
              acc_q <= acc_q + {24'h000000, energyQuanta};
            if (winEnd) begin
              phase_q <= PH_WAIT;
              tick_q  <= 24'h000000;
            end else begin
              tick_q <= tick_q + 24'h000001;
            end
          end
          PH_WAIT: begin
            // Wait phase lasts exactly one measurement window
            if (winEnd) begin
              phase_q <= PH_MEAS;
              tick_q  <= 24'h000000;
              acc_q   <= 32'h00000000;
              monData <= acc_q;
              monDone <= 1'b1;
            end else begin
              tick_q <= tick_q + 24'h000001;
            end
          end
          default: phase_q <= PH_IDLE;
        endcase
      end
    end
  end
endmodule // hsc_power_monitor

// [hdl/hsc_control.v]
// Operating-state machine, switch steering, pin sampling and interrupt of the harvester
// How it works
// - Open storage switch at overcharge threshold
// - No keep-alive, low supply: boost feeds supply
// - Keep-alive: pass switch feeds supply, never boost
// - Extract only while source above setpoint
// - Thermistor evaluated every 8 seconds
// - Monitor counts pulses or integrates energy
// - Monitor waits one window after measuring
// - Result sets done flag, data, enabled interrupt
// - High-power mode automatic unless enable cleared
// - Rising edge interrupt; only ready enabled initially
// - Enables writable; host reads flags for cause
// - Reset until 2.2 V, sample pins, sense
// - Sense storage and temperature, then supply
// - Supply lost: keep-alive stays, else reset
// - Sleep only if enabled and setpoint <= 0x0C
// - Pins resampled 2 s, charge-disable 1 s
// - Floating pins read 1, charge-disable 0
// - Interrupt low throughout reset state
// - After update, registers replace pins
// - Below 2 V, registers lost, reset state
`timescale 1ns/1ns
`include "hsc_consts.vh"
module hsc_control #(
  parameter THERM_CYCLES = `HSC_THERM_PERIOD_MS * `HSC_CLK_KHZ,
  parameter CFG_CYCLES   = `HSC_CFG_PERIOD_MS * `HSC_CLK_KHZ,
  parameter DIS_CYCLES   = `HSC_DIS_PERIOD_MS * `HSC_CLK_KHZ
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        vintReached,
  input  wire        vintBelowReset,
  input  wire        vintBelowReg,
  input  wire        vintAboveHyst,
  input  wire        stoAtOvch,
  input  wire        srcAboveSetpoint,
  input  wire        srcEnergyHigh,
  input  wire        senseDone,
  input  wire        boostPulse,
  input  wire [7:0]  energyQuanta,
  input  wire [5:0]  srcLvlPins,
  input  wire [2:0]  stoCfgPins,
  input  wire        keepAlivePin,
  input  wire        chargeDisablePin,
  input  wire [9:0]  pinFloating,
  input  wire [6:0]  regSrcRegu,
  input  wire [5:0]  regOvch,
  input  wire        regKeepAlive,
  input  wire        regChargeDisable,
  input  wire        regSleepEn,
  input  wire        regHighPowerEn,
  input  wire        regApmEn,
  input  wire        regApmMode,
  input  wire [23:0] regApmWindow,
  input  wire        ctrlUpdateWr,
  input  wire        irqEnWr,
  input  wire [1:0]  irqEnData,
  input  wire        irqFlagRd,
  output reg  [3:0]  opState,
  output reg         restoreDefaults,
  output reg         updateActive,
  output reg  [1:0]  irqEnable,
  output reg  [1:0]  irqFlags,
  output reg         irqPin,
  output reg  [31:0] monData,
  output reg  [6:0]  srcSetpoint,
  output reg  [5:0]  ovchThreshold,
  output reg         storageOutputSwitch,
  output reg         internalSupplySwitch,
  output reg         storageToInternalPass,
  output reg         boostExtract,
  output reg         highPowerMode,
  output reg         stoMeasStart,
  output reg         thermEvalStart
);
  // One-hot operating states
  localparam [3:0] ST_RESET  = 4'h1;
  localparam [3:0] ST_SENSE  = 4'h2;
  localparam [3:0] ST_SUPPLY = 4'h4;
  localparam [3:0] ST_SLEEP  = 4'h8;

  // Overcharge code for each storage pin setting
  function [5:0] ovchFromPins;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    ovchFromPins = 6'h3A;
        3'h1:    ovchFromPins = 6'h31;
        3'h2:    ovchFromPins = 6'h2A;
        3'h6:    ovchFromPins = 6'h37;
        3'h7:    ovchFromPins = 6'h33;
        default: ovchFromPins = 6'h2F;
      endcase
    end
  endfunction

  // Next value of a period counter that restarts after its last count
  function [31:0] nextCount;
    input [31:0] cnt;
    input        wrap;
    begin
      if (wrap)
        nextCount = 32'h00000000;
      else
        nextCount = cnt + 32'h00000001;
    end
  endfunction

  // Analogue comparator levels come from outside the clock domain
  wire [10:0] anaSync;
  hsc_pin_sync #(
    .W (11)
  ) uAnaSync (
    .clk   (clk),
    .nrst  (nrst),
    .pinIn ({vintReached, vintBelowReset, vintBelowReg, vintAboveHyst, stoAtOvch,
             srcAboveSetpoint, srcEnergyHigh, senseDone, boostPulse, 2'h0}),
    .level (anaSync)
  );
  wire sVintOk   = anaSync[10];
  wire sVintLost = anaSync[9];
  wire sVintLow  = anaSync[8];
  wire sVintHyst = anaSync[7];
  wire sOvch     = anaSync[6];
  wire sSrcAbove = anaSync[5];
  wire sSrcHigh  = anaSync[4];
  wire sSenseOk  = anaSync[3];
  wire sPulse    = anaSync[2];

  // Floating pins resolve high, the charge-disable pin resolves low
  wire [5:0] srcLvlRaw = srcLvlPins | pinFloating[5:0];
  wire [2:0] stoCfgRaw = stoCfgPins | pinFloating[8:6];
  wire       keepRaw   = keepAlivePin | pinFloating[9];
  wire       disRaw    = chargeDisablePin;

  wire [10:0] pinSync;
  hsc_pin_sync #(
    .W (11)
  ) uPinSync (
    .clk   (clk),
    .nrst  (nrst),
    .pinIn ({srcLvlRaw, stoCfgRaw, keepRaw, disRaw}),
    .level (pinSync)
  );

  reg [3:0]  state_d;
  reg [31:0] thermCnt_q;
  reg [31:0] cfgCnt_q;
  reg [31:0] disCnt_q;
  reg [5:0]  pinSrc_q;
  reg [2:0]  pinSto_q;
  reg        pinKeep_q;
  reg        pinDis_q;
  reg        steer_q;
  reg        irqLevel_q;
  wire       monDone;
  wire [31:0] monValue;

  // Keep-alive and charge-disable registers govern only after the host validates them
  wire effKeep = updateActive ? regKeepAlive : pinKeep_q;
  wire effDis  = updateActive ? regChargeDisable : pinDis_q;
  wire active  = (opState == ST_SUPPLY) || (opState == ST_SLEEP);
  // Sleep reads the register value directly; the pins never select sleep
  wire sleepOk = regSleepEn && (regSrcRegu <= `HSC_SLEEP_MAX_SRC);
  wire cfgTick = (cfgCnt_q == CFG_CYCLES - 1);
  wire disTick = (disCnt_q == DIS_CYCLES - 1);
  // Supply sagging, source too weak to restore it and no battery fallback
  wire supplyLost = active && sVintLow && !sSrcAbove && !effKeep;

  // Next operating state
  always @* begin
    state_d = opState;
    case (opState)
      ST_RESET: begin
        if (sVintOk && !sVintLost)
          state_d = ST_SENSE;
      end
      ST_SENSE: begin
        if (sSenseOk)
          state_d = ST_SUPPLY;
      end
      ST_SUPPLY: begin
        if (sleepOk)
          state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!sleepOk)
          state_d = ST_SUPPLY;
      end
      default: state_d = ST_RESET;
    endcase
    // Supply loss: the battery keeps the logic alive only with keep-alive
    if (supplyLost)
      state_d = ST_RESET;
    if (sVintLost)
      state_d = ST_RESET;
  end

  // Entering reset clears the event path on that same edge, so the pin
  // is never seen high while the state already reads reset
  wire enterReset = (state_d == ST_RESET);
  // Leaving sensing for supply is the bus-ready event
  wire readyEvent = (opState == ST_SENSE) && (state_d == ST_SUPPLY);

  // State, configuration capture and volatile settings
  always @(posedge clk) begin
    if (!nrst) begin
      opState         <= ST_RESET;
      restoreDefaults <= 1'b0;
      updateActive    <= 1'b0;
      irqEnable       <= `HSC_IRQ_EN_RESET;
      pinSrc_q        <= 6'h00;
      pinSto_q        <= 3'h0;
      pinKeep_q       <= 1'b0;
      pinDis_q        <= 1'b0;
      cfgCnt_q        <= 32'h00000000;
      disCnt_q        <= 32'h00000000;
      stoMeasStart    <= 1'b0;
    end else begin
      opState         <= state_d;
      restoreDefaults <= 1'b0;
      stoMeasStart    <= 1'b0;
      if (opState == ST_RESET) begin
        // Volatile settings are lost while in reset
        updateActive <= 1'b0;
        irqEnable    <= `HSC_IRQ_EN_RESET;
        cfgCnt_q     <= 32'h00000000;
        disCnt_q     <= 32'h00000000;
        if (state_d == ST_SENSE) begin
          restoreDefaults <= 1'b1;
          stoMeasStart    <= 1'b1;
          pinSrc_q        <= pinSync[10:5];
          pinSto_q        <= pinSync[4:2];
          pinKeep_q       <= pinSync[1];
          pinDis_q        <= pinSync[0];
        end
      end else begin
        if (ctrlUpdateWr)
          updateActive <= 1'b1;
        if (irqEnWr)
          irqEnable <= irqEnData;
        // Periodic resampling lets pins change while running
        cfgCnt_q <= nextCount(cfgCnt_q, cfgTick);
        disCnt_q <= nextCount(disCnt_q, disTick);
        if (cfgTick) begin
          pinSrc_q  <= pinSync[10:5];
          pinSto_q  <= pinSync[4:2];
          pinKeep_q <= pinSync[1];
        end
        if (disTick)
          pinDis_q <= pinSync[0];
      end
    end
  end

  // Periodic thermistor evaluation; a first one runs during sensing
  always @(posedge clk) begin
    if (!nrst) begin
      thermCnt_q     <= 32'h00000000;
      thermEvalStart <= 1'b0;
    end else begin
      thermEvalStart <= 1'b0;
      if (opState == ST_RESET) begin
        thermCnt_q <= 32'h00000000;
        if (state_d == ST_SENSE)
          thermEvalStart <= 1'b1;
      end else if (thermCnt_q == THERM_CYCLES - 1) begin
        thermCnt_q     <= 32'h00000000;
        thermEvalStart <= 1'b1;
      end else begin
        thermCnt_q <= thermCnt_q + 32'h00000001;
      end
    end
  end

  // Monitor runs only in the supply and sleep states; dropping the enable restarts its window
  hsc_power_monitor uMonitor (
    .clk          (clk),
    .nrst         (nrst),
    .enable       (regApmEn && active),
    .mode         (regApmMode),
    .windowCycles (regApmWindow),
    .boostPulse   (sPulse),
    .energyQuanta (energyQuanta),
    .monDone      (monDone),
    .monData      (monValue)
  );

  // Sticky flags: a new event in the read cycle wins over the clear
  always @(posedge clk) begin
    if (!nrst) begin
      irqFlags   <= 2'h0;
      irqLevel_q <= 1'b0;
      irqPin     <= 1'b0;
      monData    <= 32'h00000000;
    end else if (opState == ST_RESET || enterReset) begin
      irqFlags   <= 2'h0;
      irqLevel_q <= 1'b0;
      irqPin     <= 1'b0;
    end else begin
      irqFlags[`HSC_IRQ_BIT_READY] <= (irqFlags[`HSC_IRQ_BIT_READY] && !irqFlagRd)
                                      || readyEvent;
      irqFlags[`HSC_IRQ_BIT_MON] <= (irqFlags[`HSC_IRQ_BIT_MON] && !irqFlagRd)
                                    || monDone;
      if (monDone)
        monData <= monValue;
      // Pin level is any enabled pending flag, so a new cause gives an edge only if no enabled flag was pending
      irqLevel_q <= |(irqFlags & irqEnable);
      irqPin     <= irqLevel_q;
    end
  end

  // Charge-path steering; boost never feeds the supply under keep-alive
  always @(posedge clk) begin
    if (!nrst) begin
      steer_q               <= 1'b0;
      storageOutputSwitch   <= 1'b0;
      internalSupplySwitch  <= 1'b0;
      storageToInternalPass <= 1'b0;
      boostExtract          <= 1'b0;
      highPowerMode         <= 1'b0;
      srcSetpoint           <= 7'h00;
      ovchThreshold         <= 6'h00;
    end else begin
      // Latched until the supply clears its hysteresis, so the switch cannot chatter
      if (!active || effKeep || sVintHyst)
        steer_q <= 1'b0;
      else if (sVintLow)
        steer_q <= 1'b1;
      internalSupplySwitch  <= steer_q && !effKeep;
      storageToInternalPass <= active && effKeep && sVintLow;
      storageOutputSwitch   <= active && !steer_q && !sOvch && !effDis;
      boostExtract          <= (opState == ST_SUPPLY) && sSrcAbove;
      highPowerMode         <= (opState == ST_SUPPLY) && sSrcAbove && sSrcHigh
                               && regHighPowerEn;
      // Pin setpoint code is zero-extended into the wider register field
      srcSetpoint   <= updateActive ? regSrcRegu : {1'b0, pinSrc_q};
      ovchThreshold <= updateActive ? regOvch : ovchFromPins(pinSto_q);
    end
  end
endmodule // hsc_control

// [tb/hsc_ctl_props.sv]
// Concurrent checks on the ports of the harvester control block
`timescale 1ns/1ns
module hsc_ctl_props (
  input wire       clk,
  input wire       nrst,
  input wire       vintBelowReset,
  input wire       stoAtOvch,
  input wire       srcAboveSetpoint,
  input wire [6:0] regSrcRegu,
  input wire       regKeepAlive,
  input wire       regSleepEn,
  input wire       updateActive,
  input wire [3:0] opState,
  input wire       restoreDefaults,
  input wire [1:0] irqEnable,
  input wire [1:0] irqFlags,
  input wire       irqPin,
  input wire       storageOutputSwitch,
  input wire       internalSupplySwitch,
  input wire       boostExtract,
  input wire       stoMeasStart,
  input wire       thermEvalStart
);
  // Enabled pending cause; the pin follows it after its output delay
  wire irqAny = |(irqFlags & irqEnable);

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // The pin is cleared on the very edge that enters reset
  chk_irq_low_reset: assert property (opState == 4'h1 |-> !irqPin)
    else $error("interrupt pin high in reset state");
  chk_ovch_open: assert property (stoAtOvch [*8] |-> !storageOutputSwitch)
    else $error("storage switch closed at overcharge");
  chk_steer_open: assert property (internalSupplySwitch [*2] |-> !storageOutputSwitch)
    else $error("both output switches closed");
  chk_keep_no_boost: assert property ((updateActive && regKeepAlive) [*8]
    |-> !internalSupplySwitch)
    else $error("boost supply switch used with keep-alive");
  chk_no_extract: assert property (!srcAboveSetpoint [*8] |-> !boostExtract)
    else $error("extraction below setpoint");
  chk_sleep_entry: assert property ($rose(opState[3]) |->
    $past(regSleepEn) && $past(regSrcRegu) <= 7'h0C)
    else $error("sleep entered without its conditions");
  // Leaving reset goes to sensing with fresh defaults and a one-cycle restore
  chk_cold_exit: assert property ($fell(opState[0]) |-> (opState == 4'h2 &&
    restoreDefaults && !updateActive && stoMeasStart && thermEvalStart &&
    irqEnable == 2'h1) ##1 !restoreDefaults)
    else $error("bad exit from reset state");
  chk_irq_cause: assert property ($rose(irqPin) |-> $past(irqAny, 2) || $past(irqAny, 3))
    else $error("interrupt edge without enabled flag");
  chk_brownout: assert property (vintBelowReset [*8] |-> opState == 4'h1)
    else $error("not in reset below reset level");
endmodule // hsc_ctl_props

bind hsc_control hsc_ctl_props i_props (.clk, .nrst, .vintBelowReset, .stoAtOvch,
  .srcAboveSetpoint, .regSrcRegu, .regKeepAlive, .regSleepEn, .updateActive, .opState,
  .restoreDefaults, .irqEnable, .irqFlags, .irqPin, .storageOutputSwitch,
  .internalSupplySwitch, .boostExtract, .stoMeasStart, .thermEvalStart);

// [tb/hsc_host_model.sv]
// Host processor model: reacts to interrupt edges, reads flags, configures when ready
`timescale 1ns/1ns
module hsc_host_model (
  input  wire       clk,
  input  wire       irqPin,
  input  wire [1:0] irqFlags,
  input  wire [7:0] slowCycles,
  output reg        ctrlUpdateWr,
  output reg        irqEnWr,
  output reg  [1:0] irqEnData,
  output reg        irqFlagRd,
  output reg  [1:0] lastFlags,
  output reg  [7:0] nEdges
);
  // Accesses only follow an edge, so nothing is sent while the block sits in reset
  initial begin
    {ctrlUpdateWr, irqEnWr, irqEnData, irqFlagRd, lastFlags, nEdges} = 15'h0;
    forever begin
      @(posedge irqPin);
      repeat (slowCycles) @(negedge clk);
      @(negedge clk);
      lastFlags = irqFlags;
      irqFlagRd = 1'h1;
      // A ready event means registers were lost, so configure again
      if (irqFlags[0]) begin
        irqEnWr = 1'h1;
        irqEnData = 2'h3;
        ctrlUpdateWr = 1'h1;
      end
      @(negedge clk);
      {ctrlUpdateWr, irqEnWr, irqFlagRd} = 3'h0;
      nEdges = nEdges + 8'h1;
    end
  end
endmodule // hsc_host_model

// [tb/tb_top.sv]
// Self-checking bench for the harvester control block
`timescale 1ns/1ns
module tb_top;
  localparam int THERM = 50;
  localparam int CFG = 40;
  localparam int DIS = 20;
  reg         clk, nrst, vintReached, vintBelowReset, vintBelowReg, vintAboveHyst;
  reg         stoAtOvch, srcAboveSetpoint, srcEnergyHigh, senseDone, boostPulse;
  reg         keepAlivePin, chargeDisablePin, regKeepAlive, regChargeDisable, regSleepEn;
  reg         regHighPowerEn, regApmEn, regApmMode;
  reg  [7:0]  energyQuanta, slowCycles;
  reg  [5:0]  srcLvlPins, regOvch;
  reg  [2:0]  stoCfgPins;
  reg  [9:0]  pinFloating;
  reg  [6:0]  regSrcRegu;
  reg  [23:0] regApmWindow;
  reg  [31:0] r;
  wire        ctrlUpdateWr, irqEnWr, irqFlagRd, updateActive, irqPin, highPowerMode;
  wire        storageOutputSwitch, internalSupplySwitch, storageToInternalPass;
  wire        boostExtract, thermEvalStart;
  wire [1:0]  irqEnData, irqEnable, irqFlags, lastFlags;
  wire [3:0]  opState;
  wire [7:0]  nEdges;
  wire [6:0]  srcSetpoint;
  wire [5:0]  ovchThreshold;
  wire [31:0] monData;
  integer     n_errors, n_tests, seed, cnt;

  hsc_control #(.THERM_CYCLES(THERM), .CFG_CYCLES(CFG), .DIS_CYCLES(DIS)) i_dut (
    .clk, .nrst, .vintReached, .vintBelowReset, .vintBelowReg, .vintAboveHyst, .stoAtOvch,
    .srcAboveSetpoint, .srcEnergyHigh, .senseDone, .boostPulse, .energyQuanta, .srcLvlPins,
    .stoCfgPins, .keepAlivePin, .chargeDisablePin, .pinFloating, .regSrcRegu, .regOvch,
    .regKeepAlive, .regChargeDisable, .regSleepEn, .regHighPowerEn, .regApmEn, .regApmMode,
    .regApmWindow, .ctrlUpdateWr, .irqEnWr, .irqEnData, .irqFlagRd, .opState,
    .restoreDefaults(), .updateActive, .irqEnable, .irqFlags, .irqPin, .monData, .srcSetpoint,
    .ovchThreshold, .storageOutputSwitch, .internalSupplySwitch, .storageToInternalPass,
    .boostExtract, .highPowerMode, .stoMeasStart(), .thermEvalStart);

  hsc_host_model i_host (.clk, .irqPin, .irqFlags, .slowCycles, .ctrlUpdateWr, .irqEnWr,
    .irqEnData, .irqFlagRd, .lastFlags, .nEdges);

  // Clock at 10 MHz
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait for a state, then compare it
  task automatic waitState(input logic [3:0] s);
    int k;
    k = 0;
    while (opState !== s && k < 500) begin
      @(negedge clk);
      k++;
    end
    check("opState", s, opState);
  endtask

  task automatic waitHost;
    logic [7:0] n0;
    int k;
    n0 = nEdges;
    k = 0;
    while (nEdges === n0 && k < 600) begin
      @(negedge clk);
      k++;
    end
    check("hostEdges", n0 + 8'h1, nEdges);
  endtask

  // Overcharge code chosen by the storage pins
  function automatic logic [5:0] ovchOf(input logic [2:0] c);
    case (c)
      3'h0: ovchOf = 6'h3A;
      3'h1: ovchOf = 6'h31;
      3'h2: ovchOf = 6'h2A;
      3'h6: ovchOf = 6'h37;
      3'h7: ovchOf = 6'h33;
      default: ovchOf = 6'h2F;
    endcase
  endfunction

  task test_done;
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Guard against a hang: the sequence needs under a thousand cycles
  initial begin
    #2000000;
    n_errors++;
    test_done;
  end

  initial begin
    {vintReached, vintBelowReset, vintBelowReg, vintAboveHyst, stoAtOvch, srcAboveSetpoint,
     srcEnergyHigh, senseDone, keepAlivePin, chargeDisablePin, regKeepAlive, regChargeDisable,
     regSleepEn, regApmEn, regApmMode, pinFloating, regOvch} = '0;
    {n_errors, n_tests, cnt} = '0;
    seed = 32'hA04191DD;
    r = $random(seed);
    srcLvlPins = r[5:0];
    stoCfgPins = r[10:8];
    regOvch = r[29:24];
    regSrcRegu = {2'h1, r[20:16]};
    energyQuanta = 8'h0;
    regApmWindow = 24'h4;
    boostPulse = 1'h1;
    regHighPowerEn = 1'h1;
    slowCycles = 8'd100;
    nrst = 1'h0;
    settle(6);
    check("opState", 4'h1, opState);
    check("irqEnable", 2'h1, irqEnable);
    check("irqPin", 1'h0, irqPin);
    nrst = 1'h1;
    settle(10);
    check("opState", 4'h1, opState);
    vintReached = 1'h1;
    waitState(4'h2);
    settle(1);
    check("srcSetpoint", {1'h0, srcLvlPins}, srcSetpoint);
    check("ovchThreshold", ovchOf(stoCfgPins), ovchThreshold);
    // Floating pins must read as ones at the next resample
    pinFloating = 10'h3FF;
    settle(CFG + 10);
    check("srcSetpoint", 7'h3F, srcSetpoint);
    check("ovchThreshold", 6'h33, ovchThreshold);
    pinFloating = 10'h000;
    srcAboveSetpoint = 1'h1;
    senseDone = 1'h1;
    waitState(4'h4);
    settle(10);
    check("boostExtract", 1'h1, boostExtract);
    chargeDisablePin = 1'h1;
    settle(DIS + 8);
    check("storageOutputSwitch", 1'h0, storageOutputSwitch);
    chargeDisablePin = 1'h0;
    settle(DIS + 8);
    check("storageOutputSwitch", 1'h1, storageOutputSwitch);
    waitHost;
    check("lastFlags", 2'h1, lastFlags);
    slowCycles = 8'h0;
    settle(4);
    check("updateActive", 1'h1, updateActive);
    srcLvlPins = ~srcLvlPins;
    settle(CFG + 10);
    check("srcSetpoint", regSrcRegu, srcSetpoint);
    check("ovchThreshold", regOvch, ovchThreshold);
    regChargeDisable = 1'h1;
    settle(3);
    check("storageOutputSwitch", 1'h0, storageOutputSwitch);
    regChargeDisable = 1'h0;
    repeat (4 * THERM) begin
      @(negedge clk);
      cnt += thermEvalStart;
    end
    check("thermCount", 4, cnt);
    // Monitor in both modes with random windows and quanta
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      regApmMode = i[0];
      regApmWindow = {20'h0, r[3:0]} + 24'h4;
      energyQuanta = r[15:8];
      regApmEn = 1'h1;
      waitHost;
      check("lastFlags", 2'h2, lastFlags);
      check("monData", i[0] ? regApmWindow * energyQuanta : regApmWindow, monData);
      regApmEn = 1'h0;
      settle(2);
    end
    srcEnergyHigh = 1'h1;
    settle(10);
    check("highPowerMode", 1'h1, highPowerMode);
    regHighPowerEn = 1'h0;
    settle(10);
    check("highPowerMode", 1'h0, highPowerMode);
    stoAtOvch = 1'h1;
    settle(10);
    check("storageOutputSwitch", 1'h0, storageOutputSwitch);
    stoAtOvch = 1'h0;
    settle(10);
    check("storageOutputSwitch", 1'h1, storageOutputSwitch);
    regSleepEn = 1'h1;
    regSrcRegu = 7'h0D;
    settle(12);
    check("opState", 4'h4, opState);
    regSrcRegu = 7'h0C;
    waitState(4'h8);
    regSleepEn = 1'h0;
    waitState(4'h4);
    vintBelowReg = 1'h1;
    settle(10);
    check("internalSupplySwitch", 1'h1, internalSupplySwitch);
    vintBelowReg = 1'h0;
    settle(10);
    check("internalSupplySwitch", 1'h1, internalSupplySwitch);
    vintAboveHyst = 1'h1;
    settle(10);
    check("internalSupplySwitch", 1'h0, internalSupplySwitch);
    {vintAboveHyst, srcAboveSetpoint, vintBelowReg, regKeepAlive} = 4'h3;
    settle(30);
    check("opState", 4'h4, opState);
    check("storageToInternalPass", 1'h1, storageToInternalPass);
    check("internalSupplySwitch", 1'h0, internalSupplySwitch);
    regKeepAlive = 1'h0;
    waitState(4'h1);
    slowCycles = 8'd100;
    vintBelowReg = 1'h0;
    srcAboveSetpoint = 1'h1;
    settle(8);
    waitState(4'h4);
    check("updateActive", 1'h0, updateActive);
    check("irqEnable", 2'h1, irqEnable);
    check("srcSetpoint", {1'h0, srcLvlPins}, srcSetpoint);
    vintBelowReset = 1'h1;
    waitState(4'h1);
    test_done;
  end
endmodule // tb_top
